// file: src/wdt_pkg.sv
package wdt_pkg;

   // ****************************************
   // APB register map
   // ****************************************
   localparam logic [11:0] WDT_ADDR_CTRL = 12'h000;   // Key and fixed options
   localparam logic [11:0] WDT_ADDR_STAT = 12'h004;   // Sticky status
   localparam logic [11:0] WDT_ADDR_MASK = 12'h008;   // Interrupt mask
   localparam logic [11:0] WDT_ADDR_CMD  = 12'h00C;   // Core command strobes
   localparam logic [11:0] WDT_ADDR_CNT  = 12'h010;   // Divider chain value

   // ****************************************
   // Field layout and reset values
   // ****************************************
   localparam logic [3:0] WDT_KEY_OFF = 4'hA;          // Key value that disables the timer
   localparam int WDT_KEY_LSB = 0;                      // Key field in CTRL
   localparam int WDT_CFG_EN_BIT = 4;                   // Fixed enable (read only)
   localparam int WDT_CFG_SRC_BIT = 5;                  // Fixed source (read only)
   localparam int WDT_CFG_PAIR_BIT = 6;                 // Fixed clear scheme (read only)
   localparam int WDT_CFG_TAP_LSB = 8;                  // Fixed tap select (read only)
   localparam int WDT_ST_TO_BIT = 0;                    // Expired flag
   localparam int WDT_ST_PD_BIT = 1;                    // Power-down flag
   localparam int WDT_ST_RST_BIT = 2;                   // Full reset event
   localparam int WDT_ST_WK_BIT = 3;                    // Power-down wake event
   localparam int WDT_CMD_SGL_BIT = 0;                  // Single clear
   localparam int WDT_CMD_FST_BIT = 1;                  // First paired clear
   localparam int WDT_CMD_SND_BIT = 2;                  // Second paired clear
   localparam int WDT_CMD_SLP_BIT = 3;                  // Sleep
   localparam int WDT_CMD_WAKE_BIT = 4;                 // Wake up
   localparam int WDT_CNT_W = 16;                       // Divider chain width
   localparam int WDT_TAP_BASE = 12;                    // Tap 0 overflows at 2^13
   localparam logic [1:0] WDT_SYS_DIV_LAST = 2'h3;     // Core clock divided by four
   localparam int WDT_EV_W = 4;                         // Status register width

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      WDT_PAIR_NONE = 2'b00,                            // No half of pair seen
      WDT_PAIR_FST  = 2'b01,                            // First half seen last
      WDT_PAIR_SND  = 2'b10                             // Second half seen last
   } wdt_pair_e;

   typedef struct packed {
      logic enable;                                     // Fixed watchdog enable
      logic src_rc;                                     // 1: RC source, 0: core clock / 4
      logic paired;                                     // 1: paired clear scheme
      logic [1:0] tap;                                  // 0..3 selects 2^13..2^16
   } wdt_cfg_s;

   typedef struct packed {
      logic sgl;                                        // Single clear executed
      logic fst;                                        // First paired clear executed
      logic snd;                                        // Second paired clear executed
      logic slp;                                        // Sleep executed
      logic wake;                                       // Leaving power down
   } wdt_cmd_s;

endpackage

// file: src/wdt_divider.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Divider chain with a clearable last stage
// ****************************************
module wdt_divider
   import wdt_pkg::*;
(
   input wire logic clk,                                // Core clock
   input wire logic rst_b,                              // Sync reset, active low
   input wire logic tick,                               // One source clock edge
   input wire logic clr_all,                            // Clear the whole chain
   input wire logic clr_last,                           // Clear only the last stage
   input wire logic [1:0] tap,                          // Overflow tap select
   output logic ovf,                                    // One-cycle overflow pulse
   output logic [WDT_CNT_W-1:0] cnt                     // Chain value
);

   logic [WDT_CNT_W-1:0] cnt_ff;                        // Chain state
   logic [WDT_CNT_W-1:0] nxt_cnt;                       // Chain after one tick
   int top;                                             // Last stage bit index

   assign top = WDT_TAP_BASE + int'(tap);
   assign nxt_cnt = cnt_ff + 16'h0001;
   assign cnt = cnt_ff;

   // Overflow when the selected last stage rolls from one back to zero
   assign ovf = tick && !clr_all && !clr_last && cnt_ff[top] && !nxt_cnt[top];

   // Counter; clr_last hits only the last stage, the lower ones keep running; clr_all zeroes the chain
   always_ff @(posedge clk) begin
      if (!rst_b || clr_all) begin
         cnt_ff <= '0;
      end else if (clr_last) begin
         cnt_ff <= cnt_ff & ~(16'hFFFF << top);
      end else if (tick) begin
         cnt_ff <= ovf ? '0 : (nxt_cnt & ~(16'hFFFE << top));
      end
   end

   chk_ovf_tick: assert property (@(posedge clk) disable iff (!rst_b)
      ovf |-> tick) else $error("overflow without a source tick");

endmodule // wdt_divider

`default_nettype wire

// file: src/wdt_top.sv
// Contract
// - Count RC clock or core clock over four
// - Fixed disable makes clear commands no-ops; sleep and wake still act
// - Key 1010 disables, other values enable
// - Key resets to 1010
// - Tap selects division two^13 to two^16
// - Clear resets only the last stage
// - Normal overflow: full reset, set expired
// - Power-down overflow: set expired, PC/SP reset
// - Init pin, clears, sleep clear the count
// - Fixed option picks single or paired clear
// - Paired: repeats ignored, alternation clears
// - Core source stops counting in power down
// - Sleep clears count, sets PD, clears expired
// - PD cleared by power-up or good clear
`timescale 1ns/10ps
`default_nettype none

module wdt_top
   import wdt_pkg::*;
(
   input wire logic clk,                                // Core clock, 100 MHz
   input wire logic rst_b,                              // Power-on reset, sync, active low
   input wire logic init_pin_b,                         // Hardware init pin, active low
   input wire logic rc_tick,                            // Low-power RC oscillator edge
   input wire wdt_cfg_s cfg,                            // Fixed configuration options
   input wire wdt_cmd_s core_cmd,                       // Command pulses from the core
   input wire logic psel,                               // APB select
   input wire logic penable,                            // APB enable
   input wire logic pwrite,                             // APB direction
   input wire logic [11:0] paddr,                       // APB address
   input wire logic [31:0] pwdata,                      // APB write data
   output logic [31:0] prdata,                          // APB read data
   output logic pready,                                 // APB ready
   output logic pslverr,                                // APB error
   output logic full_reset_req,                         // One-cycle full device reset
   output logic pc_sp_reset_req,                        // One-cycle PC and SP reset
   output logic power_down,                             // Device in power down
   output logic irq                                     // Level interrupt
);

   // ****************************************
   // Declarations
   // ****************************************
   logic [3:0] key_ff;                                  // Software enable key
   logic pd_mode_ff;                                    // Power-down mode
   logic to_ff;                                         // Expired flag
   logic pdf_ff;                                        // Power-down flag
   logic [WDT_EV_W-1:0] stat_ff;                        // Sticky event bits
   logic [WDT_EV_W-1:0] mask_ff;                        // Interrupt mask
   logic [1:0] div4_ff;                                 // Core clock prescaler
   wdt_pair_e pair_ff;                                  // Last half of pair seen
   logic [31:0] prdata_ff;                              // Registered read data
   logic full_rst_ff;                                   // Reset request register
   logic pcsp_rst_ff;                                   // PC/SP reset request register
   logic running;                                       // Chain is counting
   logic tick;                                          // Source edge into chain
   logic ovf;                                           // Overflow pulse
   logic [WDT_CNT_W-1:0] cnt;                           // Chain value
   logic wr;                                            // APB write strobe
   logic rd;                                            // APB read strobe
   logic hit;                                           // Mapped address
   logic cmd_en;                                        // Clear commands take effect
   logic sw_clear;                                      // Successful software clear
   logic slp;                                           // Accepted sleep
   logic wake;                                          // Accepted wake
   wdt_cmd_s bus_cmd;                                   // Command strobes from APB
   wdt_cmd_s cmd;                                       // Merged commands
   logic [WDT_EV_W-1:0] ev;                             // Events this cycle

   // ****************************************
   // APB decode
   // ****************************************
   function automatic logic mapped(input logic [11:0] a);
      mapped = (a == WDT_ADDR_CTRL) || (a == WDT_ADDR_STAT) || (a == WDT_ADDR_MASK) ||
               (a == WDT_ADDR_CMD) || (a == WDT_ADDR_CNT);
   endfunction

   // Zero wait states; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign hit = mapped(paddr);
   assign pslverr = psel && penable && !hit;
   assign wr = psel && penable && pwrite && hit;
   assign rd = psel && penable && !pwrite && hit;
   // Command register strobes, one named bit per core instruction; a plain cast would
   // put the single clear on the top bit and the wake on bit zero
   always_comb begin
      bus_cmd = '0;
      if (wr && paddr == WDT_ADDR_CMD) begin
         bus_cmd.sgl = pwdata[WDT_CMD_SGL_BIT];
         bus_cmd.fst = pwdata[WDT_CMD_FST_BIT];
         bus_cmd.snd = pwdata[WDT_CMD_SND_BIT];
         bus_cmd.slp = pwdata[WDT_CMD_SLP_BIT];
         bus_cmd.wake = pwdata[WDT_CMD_WAKE_BIT];
      end
   end

   assign cmd = core_cmd | bus_cmd;

   // ****************************************
   // Enable and command qualification
   // ****************************************
   // Fixed disable turns the clear commands into no-ops; sleep and wake still change power down
   assign cmd_en = cfg.enable;
   assign running = cfg.enable && (key_ff != WDT_KEY_OFF);
   assign slp = cmd.slp && !pd_mode_ff;
   assign wake = cmd.wake && pd_mode_ff;

   // Clear scheme chosen by a fixed option
   always_comb begin
      sw_clear = 1'b0;
      if (cmd_en && !cfg.paired) begin
         sw_clear = cmd.sgl;
      end else if (cmd_en) begin
         // Only the opposite half of the pair completes a clear
         sw_clear = (cmd.fst && pair_ff == WDT_PAIR_SND) ||
                    (cmd.snd && pair_ff == WDT_PAIR_FST);
      end
   end

   // Pair tracker; a repeat just re-marks the same half
   // It keeps the half that completed a clear, so the pair may keep alternating
   always_ff @(posedge clk) begin
      if (!rst_b || !init_pin_b) begin
         pair_ff <= WDT_PAIR_NONE;
      end else if (cmd_en && cfg.paired && cmd.fst) begin
         pair_ff <= WDT_PAIR_FST;
      end else if (cmd_en && cfg.paired && cmd.snd) begin
         pair_ff <= WDT_PAIR_SND;
      end
   end

   // ****************************************
   // Source clock selection
   // ****************************************
   // Prescaler frozen in power down because the core clock stops there
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         div4_ff <= '0;
      end else if (!pd_mode_ff) begin
         div4_ff <= div4_ff + 2'h1;
      end
   end

   // RC edges keep arriving in power down; core/4 edges do not
   assign tick = running && (cfg.src_rc ? rc_tick :
                 (!pd_mode_ff && div4_ff == WDT_SYS_DIV_LAST));

   wdt_divider u_div (
      .clk(clk),
      .rst_b(rst_b),
      .tick(tick),
      .clr_all(!init_pin_b),
      .clr_last(sw_clear || (slp && cmd_en)),
      .tap(cfg.tap),
      .ovf(ovf),
      .cnt(cnt)
   );

   // ****************************************
   // Power-down state and status flags
   // ****************************************
   // Mode: entered by sleep, left by wake, overflow or reset
   always_ff @(posedge clk) begin
      if (!rst_b || !init_pin_b) begin
         pd_mode_ff <= 1'b0;
      end else if (slp) begin
         pd_mode_ff <= 1'b1;
      end else if (wake || ovf) begin
         pd_mode_ff <= 1'b0;
      end
   end

   // Expired flag: overflow sets it, sleep clears it; the set wins
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         to_ff <= 1'b0;
      end else if (ovf) begin
         to_ff <= 1'b1;
      end else if (slp) begin
         to_ff <= 1'b0;
      end
   end

   // Power-down flag: sleep sets it, a completed clear drops it
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pdf_ff <= 1'b0;
      end else if (slp) begin
         pdf_ff <= 1'b1;
      end else if (sw_clear) begin
         pdf_ff <= 1'b0;
      end
   end

   // Reset requests: full reset in normal run, PC/SP only in power down
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         full_rst_ff <= 1'b0;
         pcsp_rst_ff <= 1'b0;
      end else begin
         full_rst_ff <= ovf && !pd_mode_ff;
         pcsp_rst_ff <= ovf && pd_mode_ff;
      end
   end

   assign full_reset_req = full_rst_ff;
   assign pc_sp_reset_req = pcsp_rst_ff;
   assign power_down = pd_mode_ff;

   // ****************************************
   // Software key, mask and interrupt status
   // ****************************************
   // Key powers up in the disabled value; the init pin leaves it alone
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         key_ff <= WDT_KEY_OFF;
      end else if (wr && paddr == WDT_ADDR_CTRL) begin
         key_ff <= pwdata[WDT_KEY_LSB +: 4];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         mask_ff <= '0;
      end else if (wr && paddr == WDT_ADDR_MASK) begin
         mask_ff <= pwdata[WDT_EV_W-1:0];
      end
   end

   // Events: expired, power-down entry, full reset, wake reset
   always_comb begin
      ev = '0;
      ev[WDT_ST_TO_BIT] = ovf;
      ev[WDT_ST_PD_BIT] = slp;
      ev[WDT_ST_RST_BIT] = ovf && !pd_mode_ff;
      ev[WDT_ST_WK_BIT] = ovf && pd_mode_ff;
   end

   // Read clears; an event in the same cycle survives the clear
   // Only the bits captured at setup are cleared, so an event between setup and access stays
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         stat_ff <= '0;
      end else if (rd && paddr == WDT_ADDR_STAT) begin
         stat_ff <= (stat_ff & ~prdata_ff[WDT_EV_W-1:0]) | ev;
      end else begin
         stat_ff <= stat_ff | ev;
      end
   end

   assign irq = |(stat_ff & mask_ff);

   // ****************************************
   // Read data
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         prdata_ff <= '0;
      end else if (psel && !penable && !pwrite) begin
         prdata_ff <= '0;
         case (paddr)
            WDT_ADDR_CTRL: begin
               prdata_ff[WDT_KEY_LSB +: 4] <= key_ff;
               prdata_ff[WDT_CFG_EN_BIT] <= cfg.enable;
               prdata_ff[WDT_CFG_SRC_BIT] <= cfg.src_rc;
               prdata_ff[WDT_CFG_PAIR_BIT] <= cfg.paired;
               prdata_ff[WDT_CFG_TAP_LSB +: 2] <= cfg.tap;
            end
            WDT_ADDR_STAT: begin
               prdata_ff[WDT_EV_W-1:0] <= stat_ff;
               prdata_ff[WDT_EV_W+0] <= to_ff;
               prdata_ff[WDT_EV_W+1] <= pdf_ff;
            end
            WDT_ADDR_MASK: begin
               prdata_ff[WDT_EV_W-1:0] <= mask_ff;
            end
            WDT_ADDR_CNT: begin
               prdata_ff[WDT_CNT_W-1:0] <= cnt;
            end
            default: begin
               prdata_ff <= '0;
            end
         endcase
      end
   end

   assign prdata = prdata_ff;

   // ****************************************
   // Checks
   // ****************************************
   sequence s_sleep;
      slp && cmd_en;
   endsequence

   chk_key_reset: assert property (@(posedge clk)
      !rst_b |=> key_ff == WDT_KEY_OFF) else $error("key not 1010 after reset");
   chk_key_stops: assert property (@(posedge clk) disable iff (!rst_b)
      key_ff == WDT_KEY_OFF |-> !tick) else $error("tick while key disables");
   chk_cfg_off: assert property (@(posedge clk) disable iff (!rst_b)
      !cfg.enable |-> !sw_clear && !ovf) else $error("disabled timer acted");
   chk_core_pd: assert property (@(posedge clk) disable iff (!rst_b)
      pd_mode_ff && !cfg.src_rc |-> !tick) else $error("core source ran in power down");
   chk_full_rst: assert property (@(posedge clk) disable iff (!rst_b)
      ovf && !pd_mode_ff |=> full_reset_req && !pc_sp_reset_req && to_ff)
      else $error("normal overflow mishandled");
   chk_pd_rst: assert property (@(posedge clk) disable iff (!rst_b)
      ovf && pd_mode_ff |=> pc_sp_reset_req && !full_reset_req && to_ff)
      else $error("power-down overflow mishandled");
   chk_sleep_flags: assert property (@(posedge clk) disable iff (!rst_b)
      s_sleep and !ovf |=> pdf_ff && !to_ff && pd_mode_ff) else $error("sleep flags wrong");
   chk_pair_repeat: assert property (@(posedge clk) disable iff (!rst_b)
      cfg.paired && cmd.fst && pair_ff == WDT_PAIR_FST |-> !sw_clear)
      else $error("repeated first clear cleared");
   chk_pdf_clear: assert property (@(posedge clk) disable iff (!rst_b)
      sw_clear && !slp |=> !pdf_ff) else $error("clear left power-down flag");
   chk_init_pin: assert property (@(posedge clk) disable iff (!rst_b)
      !init_pin_b |=> cnt == '0) else $error("init pin did not clear count");

   // Paired scheme: the tracker must remember the half that ran last
   sequence s_fst_seen;
      cmd_en && cfg.paired && cmd.fst && !cmd.snd && init_pin_b;
   endsequence

   sequence s_snd_seen;
      cmd_en && cfg.paired && cmd.snd && !cmd.fst && init_pin_b;
   endsequence

   chk_fst_marked: assert property (@(posedge clk) disable iff (!rst_b)
      s_fst_seen |=> pair_ff == WDT_PAIR_FST) else $error("first clear not remembered");
   chk_snd_marked: assert property (@(posedge clk) disable iff (!rst_b)
      s_snd_seen |=> pair_ff == WDT_PAIR_SND) else $error("second clear not remembered");
   // Reset requests never last longer than one cycle
   chk_rst_pulse: assert property (@(posedge clk) disable iff (!rst_b)
      full_reset_req || pc_sp_reset_req |=> !full_reset_req && !pc_sp_reset_req)
      else $error("reset request wider than one cycle");
   chk_ovf_status: assert property (@(posedge clk) disable iff (!rst_b)
      ovf |=> stat_ff[WDT_ST_TO_BIT] && to_ff) else $error("overflow left no trace");
   chk_wake_exit: assert property (@(posedge clk) disable iff (!rst_b)
      wake |=> !power_down) else $error("wake kept power down");
   // Sticky bits only leave through a status read
   chk_stat_hold: assert property (@(posedge clk) disable iff (!rst_b)
      !(rd && paddr == WDT_ADDR_STAT) |=> (stat_ff & $past(stat_ff)) == $past(stat_ff))
      else $error("status bit lost without a read");

endmodule // wdt_top

`default_nettype wire

// file: dv/wdt_core_model.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Processor core stand-in
// ****************************************
module wdt_core_model
   import wdt_pkg::*;
(
   input wire logic clk,                                // Core clock
   output wdt_cmd_s core_cmd,                           // One-cycle command pulses
   output logic rc_tick                                 // RC oscillator edge stream
);
   logic rc_on = 1'b1;                                  // Oscillator running; the bench may stop it

   // One RC edge per core cycle keeps runs short; stopping it freezes an RC-fed chain
   always @(posedge clk) begin
      rc_tick <= rc_on;
   end

   // Idle until a command is issued
   initial begin
      core_cmd = '0;
   end

   // One instruction: pulse for exactly one cycle, then drop
   task automatic send(input logic [4:0] c);
      @(posedge clk);
      core_cmd <= wdt_cmd_s'(c);
      @(posedge clk);
      core_cmd <= '0;
   endtask
endmodule // wdt_core_model

`default_nettype wire

// file: dv/test_watchdog_timer.sv
`timescale 1ns/10ps
`default_nettype none

module test_watchdog_timer;
   import wdt_pkg::*;
   logic clk, rst_b, init_pin_b, psel, penable, pwrite, pready, pslverr;
   logic rc_tick, full_reset_req, pc_sp_reset_req, power_down, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   wdt_cfg_s cfg;                                       // Fixed options
   wdt_cmd_s core_cmd;                                  // From the core model
   int fail_count = 0, checks_done = 0, n;
   logic err;

   wdt_top u_dut (.clk(clk), .rst_b(rst_b), .init_pin_b(init_pin_b), .rc_tick(rc_tick),
      .cfg(cfg), .core_cmd(core_cmd), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .full_reset_req(full_reset_req), .pc_sp_reset_req(pc_sp_reset_req),
      .power_down(power_down), .irq(irq));
   wdt_core_model u_core (.clk(clk), .core_cmd(core_cmd), .rc_tick(rc_tick));

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_rng(input string nm, input int lo, input int hi, input logic [31:0] g);
      chk(nm, 32'h1, 32'((g >= lo) && (g <= hi)));
   endtask
   // APB transfer; holds everything until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) fail_count++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   // Power-on reset with a new set of fixed options
   task automatic restart(input logic [4:0] c);
      @(posedge clk);
      rst_b <= 1'b0; cfg <= wdt_cfg_s'(c);
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
   endtask
   // Count cycles to a reset request; a full reset in power down is wrong
   task automatic wait_ovf(input bit pd);
      n = 0;
      do begin
         @(posedge clk);
         n++;
         if (pd && full_reset_req === 1'b1) chk("full reset in power down", 0, 1);
      end while (((pd ? pc_sp_reset_req : full_reset_req) !== 1'b1) && n < 9000);
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset_idle();
      apb(0, WDT_ADDR_CTRL, 0); chk("key", 32'h0000003A, rd);
      apb(0, 12'h014, 0); chk("unmapped err", 1, err); chk("unmapped data", 0, rd);
      wait_ovf(0); chk("idle overflow", 9000, n);
   endtask
   task automatic t_overflow_sleep();
      apb(1, WDT_ADDR_CTRL, 32'h5); wait_ovf(0); chk_rng("period", 8185, 8198, n);
      @(posedge clk); chk("pulse width", 0, full_reset_req);
      chk("irq masked", 0, irq); apb(1, WDT_ADDR_MASK, 32'h1);
      @(posedge clk); chk("irq", 1, irq);
      apb(0, WDT_ADDR_STAT, 0); chk("stat", 32'h15, rd & 32'h3F);
      @(posedge clk); chk("irq cleared", 0, irq);
      u_core.send(5'b00010); @(posedge clk); chk("power down", 1, power_down);
      apb(0, WDT_ADDR_STAT, 0); chk("stat sleep", 32'h22, rd & 32'h32);
      wait_ovf(1); chk_rng("pd overflow", 1, 8198, n);
      apb(0, WDT_ADDR_STAT, 0); chk("stat pd", 32'h39, rd & 32'h3D);
      apb(1, WDT_ADDR_CMD, 32'(1 << WDT_CMD_SLP_BIT)); @(posedge clk);
      chk("bus sleep", 1, power_down);
      u_core.send(5'b00001); @(posedge clk); chk("wake", 0, power_down);
   endtask
   task automatic t_single_clear();
      logic [31:0] a;
      restart(5'b11000); apb(1, WDT_ADDR_CTRL, 32'h5);
      repeat (5000) @(posedge clk);
      u_core.send(5'b10000); wait_ovf(0); chk_rng("after clear", 7280, 7300, n);
      u_core.rc_on <= 1'b0; apb(0, WDT_ADDR_CNT, 0); a = rd; repeat (20) @(posedge clk);
      apb(0, WDT_ADDR_CNT, 0); chk("rc stopped", a, rd);
      u_core.rc_on <= 1'b1;
   endtask
   task automatic t_paired();
      restart(5'b11100); apb(1, WDT_ADDR_CTRL, 32'h5);
      repeat (5000) @(posedge clk);
      u_core.send(5'b01000); u_core.send(5'b01000); u_core.send(5'b10000);
      apb(0, WDT_ADDR_CNT, 0); chk("repeat kept", 1, rd[12]);
      u_core.send(5'b00100); apb(0, WDT_ADDR_CNT, 0);
      chk("pair cleared", 0, rd[15:12]);
      repeat (4000) @(posedge clk);
      u_core.send(5'b01000); apb(0, WDT_ADDR_CNT, 0); chk("alternate", 0, rd[15:12]);
      init_pin_b <= 1'b0; @(posedge clk); init_pin_b <= 1'b1;
      apb(0, WDT_ADDR_CNT, 0); chk_rng("init pin", 0, 8, rd);
   endtask
   task automatic t_core_source();
      logic [31:0] a;
      restart(5'b10010); apb(1, WDT_ADDR_CTRL, 32'h5);
      apb(0, WDT_ADDR_CNT, 0); a = rd; repeat (400) @(posedge clk);
      apb(0, WDT_ADDR_CNT, 0); chk_rng("div four", 99, 102, rd - a);
      u_core.send(5'b00010); apb(0, WDT_ADDR_CNT, 0); a = rd; repeat (400) @(posedge clk);
      apb(0, WDT_ADDR_CNT, 0); chk("frozen", a, rd);
      restart(5'b01011); apb(1, WDT_ADDR_CTRL, 32'h5);
      apb(0, WDT_ADDR_CTRL, 0); chk("cfg readback", 32'h325, rd);
      u_core.send(5'b00010);
      wait_ovf(0); chk("disabled", 9000, n);
      chk("sleep still halts", 1, power_down);
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Clock, 100 MHz
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Main sequence
   initial begin
      rst_b = 1'b0; init_pin_b = 1'b1; cfg = wdt_cfg_s'(5'b11000);
      psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      t_reset_idle(); t_overflow_sleep(); t_single_clear(); t_paired(); t_core_source();
      report_and_stop();
   end
   // Watchdog: the run needs well under 80k cycles
   initial begin
      #1000000;
      fail_count++;
      report_and_stop();
   end
endmodule // test_watchdog_timer

`default_nettype wire
